//--- logic/mlp_consts.svh
// Constants for the miscellaneous log page and mode-select block.
// Assumes inclusion by bare name from the block's design files.
`ifndef MLP_CONSTS_SVH
`define MLP_CONSTS_SVH
// AXI4-Lite register byte offsets
`define MLP_A_CDB0 8'h00
`define MLP_A_CDB1 8'h04
`define MLP_A_PDATA 8'h08
`define MLP_A_STAT 8'h0C
`define MLP_A_LIDX 8'h10
`define MLP_A_LDATA 8'h14
`define MLP_A_UA 8'h18
`define MLP_A_PLEN 8'h1C
`define MLP_A_MDATA 8'h20
`define MLP_RESP_OK 2'b00
`define MLP_RESP_ERR 2'b10
// Log page layout
`define MLP_PG_CODE 6'h37
`define MLP_PG_LEN 16'h0030
`define MLP_PAR_CODE 16'h0000
`define MLP_PAR_FLAGS 8'h00
`define MLP_PAR_LEN 8'h2C
`define MLP_PG_BYTES 52
`define MLP_RSVD 8'h00
// Command decode
`define MLP_OP_MSEL6 8'h15
`define MLP_OP_RD6 8'h08
`define MLP_OP_RD10 8'h28
`define MLP_OP_WR6 8'h0A
`define MLP_OP_WR10 8'h2A
`define MLP_OP_WV10 8'h2E
`define MLP_OP_WV16 8'h8E
`define MLP_SP_BIT 8
`define MLP_BDL_IDX 8'h03
// Sense data
`define MLP_SK_ILLEGAL 4'h5
`define MLP_ASC_INV_OP 8'h20
`define MLP_ASC_INV_PAR 8'h26
// Sizes
`define MLP_N_INIT 8
`define MLP_N_PLEN 4
`define MLP_MODE_BYTES 32
`define MLP_IE_MAX 8'hFF
// Timing
`define MLP_HOUR_S 40'd3600
`define MLP_CLK_HZ 40'd125000000
`endif

//--- logic/mlp_pkg.sv
// Types for the miscellaneous log page and mode-select block.
// Assumes nothing beyond a SystemVerilog compiler.
package mlp_pkg;
  // Drive events, all from logic on the same clock
  typedef struct packed {
    logic rd_vld;
    logic [15:0] rd_n;
    logic wr_vld;
    logic [15:0] wr_n;
    logic temp_vld;
    logic [7:0] temp;
    logic reassign;
    logic ie_event;
    logic ie_warn;
    logic flash_ecc;
    logic cmd_vld;
    logic [7:0] cmd_op;
  } mlp_ev_t;
  // Parameter-list parser states
  typedef enum logic [5:0] {
    MS_IDLE = 6'b000001,
    MS_HDR = 6'b000010,
    MS_BLK = 6'b000100,
    MS_PCODE = 6'b001000,
    MS_PLEN = 6'b010000,
    MS_PBODY = 6'b100000
  } mlp_ms_state_t;
  // Command status
  typedef struct packed {
    logic busy;
    logic done;
    logic check;
    logic [3:0] key;
    logic [7:0] asc;
  } mlp_status_t;
endpackage : mlp_pkg

//--- logic/mlp_log_mode_top.sv
// Miscellaneous counters log page and six-byte mode-select handler.
// Assumes event inputs come from logic on mclk_in; software uses AXI4-Lite.
// Operation
// - Page code 37h, length 0030h, parameter 0000h, flags zero, length 2Ch.
// - Bytes 8-11 hold powered-on time in whole hours.
// - Bytes 12-19 total bytes read, 20-27 total bytes written.
// - Byte 28 holds peak temperature seen; it never falls.
// - Bytes 29-30 count reassigned logical blocks.
// - Byte 31 counts informational exceptions, saturating at FFh, warnings excluded.
// - Byte 32 media and hardware exception flags set on any exception other than a warning.
// - Bytes 33-40 count six and ten byte read commands.
// - Bytes 41-48 count write and write-and-verify commands.
// - Bytes 50-51 count flash program memory corrections.
// - Opcode 15h is mode select; length byte 4, PF bit 4, SP bit 0.
// - One mode parameter set shared by all initiators.
// - PF is ignored; data is always page formatted.
// - SP zero applies pages without saving them.
// - SP one also requests saving pages to reserved media.
// - Zero list length means no data transfer and no error.
// - Data parsed as 4-byte header, optional block descriptor, pages.
// - Page length mismatch ends with check condition, illegal request.
// - Parameter change raises unit attention 2Ah for other initiators.
// - Counters are not saved across reset or power loss.
`timescale 1ns/1ns
`include "mlp_consts.svh"
module mlp_log_mode_top
  import mlp_pkg::*;
#(
  parameter logic [39:0] HOUR_CYC = `MLP_HOUR_S * `MLP_CLK_HZ
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Drive events
  input wire mlp_ev_t ev_in,
  // Mode-select results
  output logic save_req_out,
  output logic [`MLP_N_INIT-1:0] ua_pend_out
);
  // Write channel holding
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] wd;
  logic wr_go;
  logic wr_hit;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `MLP_RESP_OK;
      aw_addr <= `MLP_RSVD;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? `MLP_RESP_OK : `MLP_RESP_ERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end
  assign wr_go = ce_in && !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  // Lanes whose strobe is low write as zero
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wd[g*8 +: 8] = w_strb[g] ? w_data[g*8 +: 8] : `MLP_RSVD;
  end
  logic we_cdb0, we_cdb1, we_pdata, we_lidx, we_ua, we_plen;
  assign we_cdb0 = wr_go && aw_addr == `MLP_A_CDB0;
  assign we_cdb1 = wr_go && aw_addr == `MLP_A_CDB1;
  assign we_pdata = wr_go && aw_addr == `MLP_A_PDATA;
  assign we_lidx = wr_go && aw_addr == `MLP_A_LIDX;
  assign we_ua = wr_go && aw_addr == `MLP_A_UA;
  assign we_plen = wr_go && aw_addr == `MLP_A_PLEN;
  assign wr_hit = we_cdb0 || we_cdb1 || we_pdata || we_lidx || we_ua || we_plen;

  // Counters and flags of the log page
  logic [39:0] hour_pre;
  logic [31:0] hours;
  logic [63:0] bytes_rd, bytes_wr, cmds_rd, cmds_wr;
  logic [7:0] max_temp, ie_cnt;
  logic [15:0] glist, flash_cnt;
  logic media_exception_flag, hardware_exception_flag;
  logic is_rd, is_wr, ie_real;
  assign is_rd = ev_in.cmd_op == `MLP_OP_RD6 || ev_in.cmd_op == `MLP_OP_RD10;
  assign is_wr = ev_in.cmd_op == `MLP_OP_WR6 || ev_in.cmd_op == `MLP_OP_WR10 ||
                 ev_in.cmd_op == `MLP_OP_WV10 || ev_in.cmd_op == `MLP_OP_WV16;
  assign ie_real = ev_in.ie_event && !ev_in.ie_warn;
  // Power-on hours, whole hours only
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hour_pre <= '0;
      hours <= '0;
    end else if (ce_in) begin
      if (hour_pre == HOUR_CYC - 40'd1) begin
        hour_pre <= '0;
        hours <= hours + 32'd1;
      end else begin
        hour_pre <= hour_pre + 40'd1;
      end
    end
  end
  // Byte totals; cleared by reset since counters are not saved
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      bytes_rd <= '0;
      bytes_wr <= '0;
    end else if (ce_in) begin
      if (ev_in.rd_vld) bytes_rd <= bytes_rd + 64'(ev_in.rd_n);
      if (ev_in.wr_vld) bytes_wr <= bytes_wr + 64'(ev_in.wr_n);
    end
  end
  // Peak temperature only rises
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) max_temp <= `MLP_RSVD;
    else if (ce_in && ev_in.temp_vld && ev_in.temp > max_temp) max_temp <= ev_in.temp;
  end
  // Reassigned blocks and flash corrections
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      glist <= '0;
      flash_cnt <= '0;
    end else if (ce_in) begin
      if (ev_in.reassign) glist <= glist + 16'd1;
      if (ev_in.flash_ecc) flash_cnt <= flash_cnt + 16'd1;
    end
  end
  // Exception count saturates; warnings are not counted
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ie_cnt <= `MLP_RSVD;
      media_exception_flag <= 1'b0;
      hardware_exception_flag <= 1'b0;
    end else if (ce_in && ie_real) begin
      if (ie_cnt != `MLP_IE_MAX) ie_cnt <= ie_cnt + 8'd1;
      media_exception_flag <= 1'b1;
      hardware_exception_flag <= 1'b1;
    end
  end
  // Received read and write commands
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cmds_rd <= '0;
      cmds_wr <= '0;
    end else if (ce_in && ev_in.cmd_vld) begin
      if (is_rd) cmds_rd <= cmds_rd + 64'd1;
      if (is_wr) cmds_wr <= cmds_wr + 64'd1;
    end
  end
  // Page image, most significant byte first at the lowest offset
  logic [`MLP_PG_BYTES*8-1:0] page_vec;
  assign page_vec = {2'b00, `MLP_PG_CODE, `MLP_RSVD, `MLP_PG_LEN, `MLP_PAR_CODE,
                     `MLP_PAR_FLAGS, `MLP_PAR_LEN, hours, bytes_rd, bytes_wr,
                     max_temp, glist, ie_cnt, media_exception_flag,
                     hardware_exception_flag, 6'h00, cmds_rd, cmds_wr,
                     `MLP_RSVD, flash_cnt};
  logic [5:0] lidx;
  logic [7:0] page_byte;
  assign page_byte = (lidx < 6'(`MLP_PG_BYTES)) ?
                     page_vec[(`MLP_PG_BYTES - 1 - lidx)*8 +: 8] : `MLP_RSVD;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) lidx <= '0;
    else if (ce_in && we_lidx) lidx <= wd[5:0];
  end

  // Reported page lengths, loaded by firmware
  logic [5:0] plen_code [`MLP_N_PLEN];
  logic [7:0] plen_len [`MLP_N_PLEN];
  logic [`MLP_N_PLEN-1:0] hit_v;
  logic [5:0] pg_code;
  logic [7:0] b;
  assign b = wd[7:0];
  for (genvar g = 0; g < `MLP_N_PLEN; g++) begin : g_plen
    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
        plen_code[g] <= '0;
        plen_len[g] <= '0;
      end else if (ce_in && we_plen && wd[1:0] == 2'(g)) begin
        plen_code[g] <= wd[13:8];
        plen_len[g] <= wd[23:16];
      end
    end
    assign hit_v[g] = plen_code[g] == pg_code && plen_len[g] == b;
  end

  // Mode-select command and parameter list parsing
  mlp_ms_state_t ms_state, next_state;
  mlp_status_t st;
  logic [31:0] cdb0;
  logic [7:0] remain, cnt, next_cnt;
  logic [4:0] wp;
  logic sp, err, last, start, byte_go, commit, chg;
  logic [2:0] init_id;
  logic [`MLP_N_INIT-1:0] ua_others;
  assign start = we_cdb1 && !st.busy;
  assign byte_go = we_pdata && st.busy;
  assign last = remain == 8'h01;
  assign commit = byte_go && last && !err;
  assign chg = commit && (wp != 5'd0 || ms_state == MS_PBODY);
  always_comb begin
    next_state = ms_state;
    next_cnt = cnt - 8'h01;
    err = 1'b0;
    unique case (ms_state)
      MS_HDR: begin
        next_cnt = cnt + 8'h01;
        if (cnt == `MLP_BDL_IDX) begin
          next_cnt = b;
          next_state = (b == `MLP_RSVD) ? MS_PCODE : MS_BLK;
        end
      end
      MS_BLK: if (cnt == 8'h01) next_state = MS_PCODE;
      MS_PCODE: next_state = MS_PLEN;
      MS_PLEN: begin
        next_cnt = b;
        err = !(|hit_v);
        next_state = (b == `MLP_RSVD) ? MS_PCODE : MS_PBODY;
      end
      MS_PBODY: if (cnt == 8'h01) next_state = MS_PCODE;
      default: next_state = MS_IDLE;
    endcase
    if (last && next_state != MS_PCODE) err = 1'b1;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) cdb0 <= '0;
    else if (ce_in && we_cdb0 && !st.busy) cdb0 <= wd;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ms_state <= MS_IDLE;
      st <= '0;
      remain <= '0;
      cnt <= '0;
      wp <= '0;
      sp <= 1'b0;
      init_id <= '0;
      pg_code <= '0;
    end else if (ce_in) begin
      if (start) begin
        if (cdb0[7:0] != `MLP_OP_MSEL6) begin
          st <= mlp_status_t'{1'b0, 1'b1, 1'b1, `MLP_SK_ILLEGAL, `MLP_ASC_INV_OP};
        end else if (wd[7:0] == `MLP_RSVD) begin
          st <= mlp_status_t'{1'b0, 1'b1, 1'b0, 4'h0, `MLP_RSVD};
        end else begin
          st <= mlp_status_t'{1'b1, 1'b0, 1'b0, 4'h0, `MLP_RSVD};
          ms_state <= MS_HDR;
          remain <= wd[7:0];
          cnt <= '0;
          wp <= '0;
          sp <= cdb0[`MLP_SP_BIT];
          init_id <= wd[18:16];
        end
      end else if (byte_go) begin
        remain <= remain - 8'h01;
        cnt <= next_cnt;
        ms_state <= next_state;
        if (ms_state == MS_PCODE) pg_code <= b[5:0];
        if (ms_state == MS_PBODY) wp <= wp + 5'd1;
        if (err) begin
          ms_state <= MS_IDLE;
          st <= mlp_status_t'{1'b0, 1'b1, 1'b1, `MLP_SK_ILLEGAL, `MLP_ASC_INV_PAR};
        end else if (last) begin
          ms_state <= MS_IDLE;
          st <= mlp_status_t'{1'b0, 1'b1, 1'b0, 4'h0, `MLP_RSVD};
        end
      end
    end
  end
  // One shared mode parameter set, applied as it arrives
  logic [7:0] mode_cur [`MLP_MODE_BYTES];
  for (genvar g = 0; g < `MLP_MODE_BYTES; g++) begin : g_mode
    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) mode_cur[g] <= `MLP_RSVD;
      else if (ce_in && byte_go && ms_state == MS_PBODY && wp == 5'(g))
        mode_cur[g] <= b;
    end
    if (g < `MLP_N_INIT) begin : g_ua
      assign ua_others[g] = chg && init_id != 3'(g);
    end
  end
  // Save request pulse toward the media writer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) save_req_out <= 1'b0;
    else if (ce_in) save_req_out <= commit && sp;
  end
  // Pending unit attention; a new set wins over a clear
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) ua_pend_out <= '0;
    else if (ce_in) ua_pend_out <= (ua_pend_out & ~(we_ua ? wd[7:0] : `MLP_RSVD)) |
                                   ua_others;
  end

  // Read decode
  logic [31:0] rd_d;
  logic rd_hit;
  always_comb begin
    rd_d = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_in)
      `MLP_A_CDB0: rd_d = cdb0;
      `MLP_A_STAT: rd_d = {16'h0000, 1'b0, st.busy, st.done, st.check, st.key, st.asc};
      `MLP_A_LIDX: rd_d = {26'h0, lidx};
      `MLP_A_LDATA: rd_d = {24'h0, page_byte};
      `MLP_A_UA: rd_d = {24'h0, ua_pend_out};
      `MLP_A_MDATA: rd_d = {24'h0, mode_cur[lidx[4:0]]};
      `MLP_A_CDB1, `MLP_A_PDATA, `MLP_A_PLEN: rd_d = '0;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `MLP_RESP_OK;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_d;
        s_axi_rresp_out <= rd_hit ? `MLP_RESP_OK : `MLP_RESP_ERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  chk_page_code_rd: assert property (ce_in && s_axi_arvalid_in && s_axi_arready_out &&
      s_axi_araddr_in == `MLP_A_LDATA && lidx == 6'd0 |=> s_axi_rdata_out[7:0] == 8'h37)
    else $error("log page code byte wrong");
  chk_hours_tick: assert property (ce_in && hour_pre == HOUR_CYC - 40'd1
      |=> hours == $past(hours) + 32'd1)
    else $error("hour count did not advance");
  chk_bytes_rd_sum: assert property (ce_in && ev_in.rd_vld
      |=> bytes_rd == $past(bytes_rd) + 64'($past(ev_in.rd_n)))
    else $error("bytes read total wrong");
  chk_temp_never_falls: assert property (ce_in |=> max_temp >= $past(max_temp))
    else $error("peak temperature fell");
  chk_ie_warn_skip: assert property (ce_in && ev_in.ie_event && ev_in.ie_warn
      |=> ie_cnt == $past(ie_cnt))
    else $error("warning was counted");
  chk_ie_flags_set: assert property (ce_in && ie_real
      |=> media_exception_flag && hardware_exception_flag && ie_cnt != 8'h00)
    else $error("exception flags not set");
  chk_rd_cmd_count: assert property (ce_in && ev_in.cmd_vld && is_rd
      |=> cmds_rd == $past(cmds_rd) + 64'd1)
    else $error("read command not counted");
  chk_wr_cmd_count: assert property (ce_in && ev_in.cmd_vld && is_wr
      |=> cmds_wr == $past(cmds_wr) + 64'd1)
    else $error("write command not counted");
  chk_zero_len_ok: assert property (ce_in && start && cdb0[7:0] == 8'h15 &&
      wd[7:0] == 8'h00 |=> !st.busy && st.done && !st.check)
    else $error("zero length treated wrongly");
  chk_len_mismatch: assert property (ce_in && byte_go && ms_state == MS_PLEN &&
      !(|hit_v) |=> st.check && st.key == 4'h5 && !st.busy && ms_state == MS_IDLE)
    else $error("page length mismatch not refused");
  chk_ua_others_set: assert property (ce_in && chg
      |=> (ua_pend_out & $past(ua_others)) == $past(ua_others) && $past(ua_others) != 8'h00)
    else $error("unit attention not raised");
  chk_save_on_sp: assert property (ce_in && commit |=> save_req_out == $past(sp))
    else $error("save request wrong");
endmodule : mlp_log_mode_top

//--- sim/mlp_host_model.sv
// Host initiator model: an AXI4-Lite master that issues commands and data.
// Assumes callers enter its tasks just after a rising edge of mclk_in.
`timescale 1ns/1ns
module mlp_host_model (
  // Clock
  input wire logic mclk_in,
  // Write channels
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  // Read channels
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  // Idle bus from time zero
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
    wstrb_out = 4'hF;
  end

  // One write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
      output bit to);
    int n;
    bit fin;
    n = 0;
    fin = 0;
    r = 2'b11;
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    while (!fin && n < 200) begin
      @(posedge mclk_in);
      n++;
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
      if (bvalid_in && bready_out) begin
        r = bresp_in;
        bready_out <= 1'b0;
        fin = 1;
      end
    end
    to = !fin;
    @(posedge mclk_in);
  endtask : wr

  // One read; data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
      output bit to);
    int n;
    bit fin;
    n = 0;
    fin = 0;
    d = '0;
    r = 2'b11;
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    while (!fin && n < 200) begin
      @(posedge mclk_in);
      n++;
      if (arvalid_out && arready_in) begin
        arvalid_out <= 1'b0;
        araddr_out <= ~a;
      end
      if (rvalid_in && rready_out) begin
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
        fin = 1;
      end
    end
    to = !fin;
    @(posedge mclk_in);
  endtask : rd
endmodule : mlp_host_model

//--- sim/tb.sv
// Self-checking bench for the log page and mode-select block.
// Assumes the host model drives the register bus; events come from this bench.
`timescale 1ns/1ns
`include "mlp_consts.svh"
module tb;
  import mlp_pkg::*;
  logic clk, rst_n, awv, awr, wv, wr, bv, br, arv, arr, rv_o, rr, save_req;
  logic [7:0] awa, ara, ua;
  logic [31:0] wd, rd_o, rv;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, resp;
  logic [63:0] v;
  logic [7:0] q[$];
  mlp_ev_t ev;
  logic ce = 1'b1;
  int bad_count = 0, comparisons = 0, saves = 0, cyc = 0, c0;
  int fi[16] = '{0, 1, 2, 4, 6, 7, 12, 20, 28, 29, 31, 32, 33, 41, 49, 50};
  int fn[16] = '{1, 1, 2, 2, 1, 1, 8, 8, 1, 2, 1, 1, 8, 8, 1, 2};
  logic [63:0] fe[16] = '{64'h37, 0, 64'h30, 0, 0, 64'h2C, 64'h11233, 64'h102, 64'h32, 3, 1,
      64'hC0, 2, 4, 0, 2};
  logic [7:0] ops[8] = '{8'h08, 8'h28, 8'h15, 8'h0A, 8'h2A, 8'h2E, 8'h8E, 8'h1A};

  mlp_log_mode_top #(.HOUR_CYC(40'd1000)) DUT (.mclk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd_o), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv_o),
    .s_axi_rready_in(rr), .ev_in(ev), .save_req_out(save_req), .ua_pend_out(ua));
  mlp_host_model u_host (.mclk_in(clk), .awaddr_out(awa), .awvalid_out(awv), .awready_in(awr),
    .wdata_out(wd), .wstrb_out(ws), .wvalid_out(wv), .wready_in(wr), .bresp_in(bresp),
    .bvalid_in(bv), .bready_out(br), .araddr_out(ara), .arvalid_out(arv), .arready_in(arr),
    .rdata_in(rd_o), .rresp_in(rresp), .rvalid_in(rv_o), .rready_out(rr));

  // Clock and cycle count since reset release
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= rst_n ? cyc + 1 : 0;
    if (rst_n && save_req === 1'b1) saves <= saves + 1;
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // Bus wrappers; a hung transfer ends the run
  task w(input logic [7:0] a, input logic [31:0] d);
    bit to;
    u_host.wr(a, d, resp, to);
    if (to) begin
      bad_count++;
      stop_test();
    end
  endtask : w
  task r(input logic [7:0] a);
    bit to;
    u_host.rd(a, rv, resp, to);
    if (to) begin
      bad_count++;
      stop_test();
    end
  endtask : r

  // Log page field of n bytes, first byte most significant
  task lf(input int i, input int n);
    v = '0;
    for (int k = 0; k < n; k++) begin
      w(`MLP_A_LIDX, 32'(i + k));
      r(`MLP_A_LDATA);
      v = {v[55:0], rv[7:0]};
    end
  endtask : lf

  task ev1(input mlp_ev_t e);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask : ev1

  // Mode select with the parameter list in q, then wait for busy to drop
  task ms(input logic [31:0] c0w, input logic [2:0] id);
    w(`MLP_A_CDB0, c0w);
    w(`MLP_A_CDB1, {13'h0, id, 8'h0, 8'(q.size())});
    foreach (q[k]) w(`MLP_A_PDATA, {24'h0, q[k]});
    for (int k = 0; k < 20; k++) begin
      r(`MLP_A_STAT);
      if (rv[14] === 1'b0) break;
    end
    // A command that never leaves busy ends the run
    if (rv[14] !== 1'b0) begin
      bad_count++;
      stop_test();
    end
  endtask : ms

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ev = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ev1('{rd_vld: 1'b1, rd_n: 16'h1234, wr_vld: 1'b1, wr_n: 16'h0102, default: '0});
    ev1('{rd_vld: 1'b1, rd_n: 16'hFFFF, default: '0});
    ev1('{temp_vld: 1'b1, temp: 8'h1E, default: '0});
    ev1('{temp_vld: 1'b1, temp: 8'h32, default: '0});
    ev1('{temp_vld: 1'b1, temp: 8'h28, default: '0});
    repeat (3) ev1('{reassign: 1'b1, default: '0});
    ev1('{ie_event: 1'b1, ie_warn: 1'b1, default: '0});
    ev1('{ie_event: 1'b1, default: '0});
    repeat (2) ev1('{flash_ecc: 1'b1, default: '0});
    foreach (ops[k]) ev1('{cmd_vld: 1'b1, cmd_op: ops[k], default: '0});
    // Events while the clock enable is low must leave the counters alone
    ce <= 1'b0;
    ev1('{reassign: 1'b1, flash_ecc: 1'b1, default: '0});
    ce <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      lf(fi[k], fn[k]);
      chk("log field", v, fe[k]);
    end
    repeat (3000) @(posedge clk);
    c0 = cyc;
    lf(8, 4);
    chk("power hours", 64'(v + 1 >= c0 / 1000 && v <= cyc / 1000), 1);
    w(`MLP_A_PLEN, 32'h0002_0100);
    q = '{0, 0, 0, 8, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 1, 2, 8'hAA, 8'h55};
    ms(32'h0000_1115, 3'd2);
    chk("status", rv[14:0], 15'h2000);
    chk("unit attention", ua, 8'hFB);
    chk("save pulses", saves, 1);
    w(`MLP_A_UA, 32'hFF);
    chk("write resp", resp, `MLP_RESP_OK);
    chk("unit attention", ua, 8'h00);
    q = '{0, 0, 0, 0, 1, 2, 8'h11, 8'h22};
    ms(32'h0000_0015, 3'd5);
    chk("status", rv[14:0], 15'h2000);
    chk("unit attention", ua, 8'hDF);
    chk("save pulses", saves, 1);
    // Second page body byte of the latest command is now current
    w(`MLP_A_LIDX, 32'h1);
    r(`MLP_A_MDATA);
    chk("mode byte", rv[7:0], 8'h22);
    chk("read resp", resp, `MLP_RESP_OK);
    q = '{0, 0, 0, 0, 1, 3};
    ms(32'h0000_1115, 3'd1);
    chk("status", rv[14:0], 15'h3526);
    chk("unit attention", ua, 8'hDF);
    w(`MLP_A_UA, 32'hFF);
    q.delete();
    ms(32'h0000_1115, 3'd3);
    chk("status", rv[14:0], 15'h2000);
    chk("unit attention", ua, 8'h00);
    ms(32'h0000_0012, 3'd0);
    chk("status", rv[14:0], 15'h3520);
    r(8'h3C);
    chk("read resp", resp, `MLP_RESP_ERR);
    w(8'h3C, 32'h0);
    chk("write resp", resp, `MLP_RESP_ERR);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    lf(33, 8);
    chk("reads after reset", v, 0);
    lf(28, 1);
    chk("peak after reset", v, 0);
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule : tb
